/* File: hdl/cfg_pkg.sv */
// Constants for the control-flow guard checker.
// Assumes a single core clock and an active-low asynchronous core reset.
`default_nettype none
package cfg_pkg;
	localparam logic [7:0] CP_VECTOR = 8'h15;
	localparam logic [63:0] PUSH8_STEP = 64'h0000_0000_0000_0008;
	localparam logic [63:0] PUSH4_STEP = 64'h0000_0000_0000_0004;
	localparam logic [63:0] PTR_RESET = 64'h0000_0000_0000_0000;
	localparam logic [1:0] USER_PRIV = 2'h3;
	// Fault cause encodings
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	localparam logic [2:0] CAUSE_RET_MISMATCH = 3'h1;
	localparam logic [2:0] CAUSE_MISSING_MARKER = 3'h2;
	localparam logic [2:0] CAUSE_STORE_PAGE = 3'h3;
	localparam logic [2:0] CAUSE_LOAD_PAGE = 3'h4;
	localparam logic [2:0] CAUSE_DATA_STORE = 3'h5;
	typedef enum logic [0:0] {
		CFG_IDLE = 1'b0,
		CFG_AWAIT = 1'b1
	} cfg_trk_t;
endpackage
`default_nettype wire

/* File: hdl/cfg_guard_checker.sv */
// Control-flow guard checker: guard stack pointer, return compare, page
// attribute checks and indirect branch tracker.
// Assumes the pipeline gives one retired-instruction event per cycle at most,
// and the paging unit presents the page attribute with each access.
`default_nettype none
module cfg_guard_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Mode and enables
	input wire logic prot_mode,
	input wire logic v86_mode,
	input wire logic long64_mode,
	input wire logic [1:0] cur_priv,
	input wire logic user_gs_en,
	input wire logic sup_gs_en,
	input wire logic ibt_en,
	input wire logic ptr_load,
	input wire logic [63:0] ptr_load_val,
	// Instruction events
	input wire logic instr_valid,
	input wire logic is_call,
	input wire logic is_ret,
	input wire logic is_indirect,
	input wire logic is_marker,
	input wire logic [63:0] ret_addr,
	input wire logic [63:0] data_pop_addr,
	// Guard stack memory side
	input wire logic [63:0] gs_rd_data,
	input wire logic gs_rd_page_attr,
	input wire logic gs_wr_page_attr,
	// Ordinary data store check
	input wire logic data_st_valid,
	input wire logic data_st_page_attr,
	// Outputs
	output logic gs_active,
	output logic [63:0] gs_ptr,
	output logic gs_wr_en,
	output logic [63:0] gs_wr_addr,
	output logic [63:0] gs_wr_data,
	output logic gs_rd_en,
	output logic [63:0] gs_rd_addr,
	output logic data_st_refuse,
	output logic trk_await,
	output logic fault,
	output logic [7:0] fault_vector,
	output logic [2:0] fault_cause
);
	logic rst_s1_ff, rst_n_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	logic en_now;
	logic [63:0] step;
	logic [63:0] wmask;
	// Per-privilege enable, protected mode only
	assign en_now = prot_mode && !v86_mode &&
		((cur_priv == cfg_pkg::USER_PRIV) ? user_gs_en : sup_gs_en);
	assign step = long64_mode ? cfg_pkg::PUSH8_STEP : cfg_pkg::PUSH4_STEP;
	assign wmask = long64_mode ? 64'hffff_ffff_ffff_ffff
		: 64'h0000_0000_ffff_ffff;

	logic do_call, do_ret, miss_marker, push_ok;
	logic [63:0] nxt_ptr, push_ptr;
	logic [2:0] nxt_cause;
	cfg_pkg::cfg_trk_t trk_ff;
	assign do_call = instr_valid && is_call && en_now;
	assign do_ret = instr_valid && is_ret && en_now;
	assign push_ptr = (gs_ptr - step) & wmask;
	assign miss_marker = instr_valid && ibt_en && trk_ff == cfg_pkg::CFG_AWAIT
		&& !is_marker;

	always_comb begin
		nxt_cause = cfg_pkg::CAUSE_NONE;
		if (miss_marker)
			nxt_cause = cfg_pkg::CAUSE_MISSING_MARKER;
		else if (do_call && !gs_wr_page_attr)
			nxt_cause = cfg_pkg::CAUSE_STORE_PAGE;
		else if (do_ret && !gs_rd_page_attr)
			nxt_cause = cfg_pkg::CAUSE_LOAD_PAGE;
		else if (do_ret && ((gs_rd_data & wmask) != (data_pop_addr & wmask)))
			nxt_cause = cfg_pkg::CAUSE_RET_MISMATCH;
		else if (data_st_valid && data_st_page_attr)
			nxt_cause = cfg_pkg::CAUSE_DATA_STORE;
	end
	assign push_ok = do_call && !ptr_load &&
		nxt_cause == cfg_pkg::CAUSE_NONE;

	always_comb begin
		nxt_ptr = gs_ptr;
		if (ptr_load)
			nxt_ptr = ptr_load_val & wmask;
		else if (nxt_cause != cfg_pkg::CAUSE_NONE)
			nxt_ptr = gs_ptr;
		else if (do_call)
			nxt_ptr = push_ptr;
		else if (do_ret)
			nxt_ptr = (gs_ptr + step) & wmask;
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			gs_ptr <= cfg_pkg::PTR_RESET;
		else
			gs_ptr <= nxt_ptr;
	end

	// Guard stack writes carry only the return address
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			gs_wr_en <= 1'b0;
			gs_wr_addr <= 64'h0;
			gs_wr_data <= 64'h0;
		end else begin
			gs_wr_en <= push_ok;
			gs_wr_addr <= push_ptr;
			gs_wr_data <= ret_addr & wmask;
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			gs_rd_en <= 1'b0;
			gs_rd_addr <= 64'h0;
		end else begin
			gs_rd_en <= do_ret;
			gs_rd_addr <= gs_ptr;
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			data_st_refuse <= 1'b0;
		else
			data_st_refuse <= data_st_valid && data_st_page_attr;
	end

	// Branch tracker; the marker itself has no other effect
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			trk_ff <= cfg_pkg::CFG_IDLE;
		else if (!ibt_en)
			trk_ff <= cfg_pkg::CFG_IDLE;
		else if (instr_valid) begin
			case (trk_ff)
				cfg_pkg::CFG_IDLE:
					if (!is_ret && is_indirect && !is_marker)
						trk_ff <= cfg_pkg::CFG_AWAIT;
				cfg_pkg::CFG_AWAIT:
					trk_ff <= cfg_pkg::CFG_IDLE;
				default:
					trk_ff <= cfg_pkg::CFG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			trk_await <= 1'b0;
		else
			trk_await <= ibt_en && instr_valid &&
				trk_ff == cfg_pkg::CFG_IDLE && is_indirect && !is_ret &&
				!is_marker;
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			fault <= 1'b0;
			fault_vector <= 8'h00;
			fault_cause <= cfg_pkg::CAUSE_NONE;
			gs_active <= 1'b0;
		end else begin
			fault <= nxt_cause != cfg_pkg::CAUSE_NONE;
			fault_vector <= (nxt_cause != cfg_pkg::CAUSE_NONE) ?
				cfg_pkg::CP_VECTOR : 8'h00;
			fault_cause <= nxt_cause;
			gs_active <= en_now;
		end
	end

	property p_vector;
		@(posedge clk) disable iff (!rst_n_ff)
		fault |-> fault_vector == cfg_pkg::CP_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector");

	property p_miss;
		@(posedge clk) disable iff (!rst_n_ff)
		miss_marker |=> fault &&
			fault_cause == cfg_pkg::CAUSE_MISSING_MARKER;
	endproperty
	a_miss: assert property (p_miss) else $error("missing marker");

	sequence s_indirect;
		ibt_en && instr_valid && trk_ff == cfg_pkg::CFG_IDLE && is_indirect
			&& !is_ret && !is_marker;
	endsequence
	property p_enter;
		@(posedge clk) disable iff (!rst_n_ff)
		s_indirect ##1 ibt_en |-> trk_ff == cfg_pkg::CFG_AWAIT;
	endproperty
	a_enter: assert property (p_enter) else $error("no await");

	property p_leave;
		@(posedge clk) disable iff (!rst_n_ff)
		trk_ff == cfg_pkg::CFG_AWAIT && instr_valid && is_marker
			|=> trk_ff == cfg_pkg::CFG_IDLE;
	endproperty
	a_leave: assert property (p_leave) else $error("no idle");

	property p_ibt_off;
		@(posedge clk) disable iff (!rst_n_ff)
		!ibt_en |=> trk_ff == cfg_pkg::CFG_IDLE;
	endproperty
	a_ibt_off: assert property (p_ibt_off) else $error("ibt off");

	property p_push;
		@(posedge clk) disable iff (!rst_n_ff)
		gs_wr_en |-> gs_wr_addr == gs_ptr && $past(gs_ptr) != gs_ptr;
	endproperty
	a_push: assert property (p_push) else $error("push order");

	property p_v86;
		@(posedge clk) disable iff (!rst_n_ff)
		v86_mode |=> !gs_active && !gs_wr_en;
	endproperty
	a_v86: assert property (p_v86) else $error("v86 active");

	property p_refuse;
		@(posedge clk) disable iff (!rst_n_ff)
		data_st_valid && data_st_page_attr |=> data_st_refuse;
	endproperty
	a_refuse: assert property (p_refuse) else $error("store ok");

	property p_wpage;
		@(posedge clk) disable iff (!rst_n_ff)
		do_call && !gs_wr_page_attr |=> fault && !gs_wr_en;
	endproperty
	a_wpage: assert property (p_wpage) else $error("store page");

	sequence s_good_ret;
		do_ret && !ptr_load && nxt_cause == cfg_pkg::CAUSE_NONE;
	endsequence
	property p_pop;
		@(posedge clk) disable iff (!rst_n_ff)
		s_good_ret |=> gs_rd_en && gs_rd_addr == $past(gs_ptr) &&
			gs_ptr != $past(gs_ptr);
	endproperty
	a_pop: assert property (p_pop) else $error("pop step");

	sequence s_bad_ret;
		do_ret && !is_call && gs_rd_page_attr && !miss_marker &&
			((gs_rd_data & wmask) != (data_pop_addr & wmask));
	endsequence
	property p_mismatch;
		@(posedge clk) disable iff (!rst_n_ff)
		s_bad_ret |=> fault &&
			fault_cause == cfg_pkg::CAUSE_RET_MISMATCH;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("ret diff");

	sequence s_ret_page;
		do_ret && !is_call && !gs_rd_page_attr && !miss_marker;
	endsequence
	property p_rpage;
		@(posedge clk) disable iff (!rst_n_ff)
		s_ret_page |=> fault && fault_cause == cfg_pkg::CAUSE_LOAD_PAGE;
	endproperty
	a_rpage: assert property (p_rpage) else $error("read page");

	property p_wdata;
		@(posedge clk) disable iff (!rst_n_ff)
		gs_wr_en && $past(long64_mode) |-> gs_wr_data == $past(ret_addr);
	endproperty
	a_wdata: assert property (p_wdata) else $error("push data");

	property p_width;
		@(posedge clk) disable iff (!rst_n_ff)
		gs_wr_en && !$past(long64_mode) |->
			gs_wr_data[63:32] == 32'h0000_0000 &&
			gs_wr_addr[63:32] == 32'h0000_0000;
	endproperty
	a_width: assert property (p_width) else $error("narrow push");

	property p_marker_nop;
		@(posedge clk) disable iff (!rst_n_ff)
		trk_ff == cfg_pkg::CFG_IDLE && instr_valid && is_marker &&
			!is_call && !is_ret && !data_st_valid
			|=> !fault && trk_ff == cfg_pkg::CFG_IDLE;
	endproperty
	a_marker_nop: assert property (p_marker_nop) else $error("marker");

	property p_nowrite;
		@(posedge clk) disable iff (!rst_n_ff)
		fault |-> !gs_wr_en;
	endproperty
	a_nowrite: assert property (p_nowrite) else $error("fault write");

	property p_priv;
		@(posedge clk) disable iff (!rst_n_ff)
		cur_priv != cfg_pkg::USER_PRIV && !sup_gs_en |=> !gs_active;
	endproperty
	a_priv: assert property (p_priv) else $error("priv enable");
endmodule // cfg_guard_checker
`default_nettype wire

/* File: verif/cfg_far_model.sv */
// Far-side model: guard stack memory and page attribute source.
// Assumes one checker write per cycle and reads that follow gs_ptr.
`default_nettype none
module cfg_far_model (
	// Clock
	input wire logic clk,
	// Checker side
	input wire logic gs_wr_en,
	input wire logic [63:0] gs_wr_addr,
	input wire logic [63:0] gs_wr_data,
	input wire logic [63:0] gs_ptr,
	// Page selection from the bench
	input wire logic page_ok,
	output logic [63:0] gs_rd_data,
	output logic gs_rd_page_attr,
	output logic gs_wr_page_attr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] mem_ff [8];
	logic [7:0] vld_ff = 8'h00;
	logic [63:0] junk_ff = 64'h0;
	always @(posedge clk) begin
		junk_ff <= ~junk_ff;
		if (gs_wr_en) begin
			mem_ff[gs_wr_addr[5:3]] <= gs_wr_data;
			vld_ff[gs_wr_addr[5:3]] <= 1'b1;
		end
	end
	// Forward a write not yet stored; unwritten words read as noise
	always_comb begin
		if (gs_wr_en && gs_wr_addr == gs_ptr)
			gs_rd_data = gs_wr_data;
		else if (vld_ff[gs_ptr[5:3]])
			gs_rd_data = mem_ff[gs_ptr[5:3]];
		else
			gs_rd_data = junk_ff;
	end
	assign gs_rd_page_attr = page_ok;
	assign gs_wr_page_attr = page_ok;
endmodule // cfg_far_model
`default_nettype wire

/* File: verif/tb_cfg_guard_checker.sv */
// Self-checking bench for the control-flow guard checker.
// Assumes the checker and the far-side model in the same compile.
`default_nettype none
module tb_cfg_guard_checker;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic prot_mode, v86_mode, long64_mode, user_gs_en, sup_gs_en, ibt_en;
	logic ptr_load, instr_valid, is_call, is_ret, is_indirect, is_marker;
	logic data_st_valid, data_st_page_attr, page_ok, gs_rd_page_attr;
	logic gs_wr_page_attr, gs_active, gs_wr_en, gs_rd_en, data_st_refuse;
	logic trk_await, fault;
	logic [1:0] cur_priv;
	logic [2:0] fault_cause;
	logic [7:0] fault_vector;
	logic [63:0] ptr_load_val, ret_addr, data_pop_addr, gs_rd_data, gs_ptr;
	logic [63:0] gs_wr_addr, gs_wr_data, gs_rd_addr;
	int miscompares = 0;
	int cmp_count = 0;
	cfg_guard_checker i_cfg_guard_checker (.*);
	cfg_far_model i_cfg_far_model (.*);
	always #20 clk = ~clk;
	task automatic chk(input string nm, input logic [63:0] e, g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// One retired instruction, outputs settled at the next falling edge
	task automatic ins(input logic v, c, r, j, m);
		instr_valid = v;
		is_call = c;
		is_ret = r;
		is_indirect = j;
		is_marker = m;
		@(negedge clk);
	endtask
	task automatic t_stack();
		ptr_load = 1'b1;
		@(negedge clk);
		ptr_load = 1'b0;
		ins(1, 1, 0, 0, 0);
		chk("active", 1, gs_active);
		chk("ptr", 64'hff8, gs_ptr);
		chk("wr_en", 1, gs_wr_en);
		chk("wr_addr", 64'hff8, gs_wr_addr);
		chk("wr_data", ret_addr, gs_wr_data);
		ins(1, 0, 1, 0, 0);
		chk("rd_addr", 64'hff8, gs_rd_addr);
		chk("rd_en", 1, gs_rd_en);
		chk("fault", 0, fault);
		chk("ptr", 64'h1000, gs_ptr);
		ins(1, 1, 0, 0, 0);
		data_pop_addr = ret_addr ^ 64'h10;
		ins(1, 0, 1, 0, 0);
		chk("fault", 1, fault);
		chk("vector", cfg_pkg::CP_VECTOR, fault_vector);
		chk("cause", cfg_pkg::CAUSE_RET_MISMATCH, fault_cause);
		ins(0, 0, 0, 0, 0);
		$display("stack test done");
	endtask
	task automatic t_page();
		page_ok = 1'b0;
		ins(1, 1, 0, 0, 0);
		chk("wr_en", 0, gs_wr_en);
		chk("cause", cfg_pkg::CAUSE_STORE_PAGE, fault_cause);
		ins(1, 0, 1, 0, 0);
		chk("cause", cfg_pkg::CAUSE_LOAD_PAGE, fault_cause);
		page_ok = 1'b1;
		ins(0, 0, 0, 0, 0);
		data_st_page_attr = 1'b1;
		data_st_valid = 1'b1;
		@(negedge clk);
		chk("refuse", 1, data_st_refuse);
		chk("cause", cfg_pkg::CAUSE_DATA_STORE, fault_cause);
		data_st_page_attr = 1'b0;
		@(negedge clk);
		chk("refuse", 0, data_st_refuse);
		data_st_valid = 1'b0;
		$display("page test done");
	endtask
	task automatic t_track();
		ins(1, 0, 0, 0, 1);
		chk("fault", 0, fault);
		ins(1, 0, 0, 1, 0);
		chk("await", 1, trk_await);
		ins(1, 0, 0, 0, 1);
		chk("fault", 0, fault);
		ins(1, 0, 0, 0, 0);
		chk("fault", 0, fault);
		ins(1, 0, 0, 1, 0);
		ins(1, 0, 0, 0, 0);
		chk("cause", cfg_pkg::CAUSE_MISSING_MARKER, fault_cause);
		ins(1, 0, 0, 1, 0);
		ibt_en = 1'b0;
		ins(1, 0, 0, 0, 0);
		chk("fault", 0, fault);
		ibt_en = 1'b1;
		ins(0, 0, 0, 0, 0);
		$display("tracker test done");
	endtask
	task automatic t_mode();
		v86_mode = 1'b1;
		@(negedge clk);
		chk("active", 0, gs_active);
		v86_mode = 1'b0;
		cur_priv = 2'h0;
		@(negedge clk);
		chk("active", 0, gs_active);
		sup_gs_en = 1'b1;
		@(negedge clk);
		chk("active", 1, gs_active);
		$display("mode test done");
	endtask
	task automatic t_narrow();
		long64_mode = 1'b0;
		ptr_load_val = 64'h0000_0001_0000_2000;
		ptr_load = 1'b1;
		@(negedge clk);
		ptr_load = 1'b0;
		chk("ptr", 64'h2000, gs_ptr);
		ret_addr = 64'hdead_0000_0040_1234;
		ins(1, 1, 0, 0, 0);
		chk("ptr", 64'h1ffc, gs_ptr);
		chk("wr_data", 64'h40_1234, gs_wr_data);
		data_pop_addr = 64'hbeef_0000_0040_1234;
		ins(1, 0, 1, 0, 0);
		chk("rd_en", 1, gs_rd_en);
		chk("fault", 0, fault);
		chk("ptr", 64'h2000, gs_ptr);
		ins(0, 0, 0, 0, 0);
		$display("narrow test done");
	endtask
	task automatic close_out();
		$display("cmp_count %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{v86_mode, sup_gs_en, ptr_load, instr_valid, is_call, is_ret} = '0;
		{is_indirect, is_marker, data_st_valid, data_st_page_attr} = '0;
		{prot_mode, long64_mode, user_gs_en, ibt_en, page_ok} = '1;
		cur_priv = cfg_pkg::USER_PRIV;
		ptr_load_val = 64'h1000;
		ret_addr = 64'h40_1234;
		data_pop_addr = 64'h40_1234;
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_stack();
		t_page();
		t_track();
		t_mode();
		t_narrow();
		close_out();
	end
	initial begin
		#50000;
		miscompares++;
		close_out();
	end
endmodule // tb_cfg_guard_checker
`default_nettype wire
